// ### src/pwrseq_top.sv
// Purpose: power-up/down, fault and sleep sequencing plus I2C target port
// Assumes: SCL/SDA sampled in the link clock domain, events cross by toggle
// Notes: register file content is outside this block; writes leave as a strobe
`timescale 1ns/1ps
module pwrseq_top
  import pwrseq_pkg::*;
(
  input wire logic i_ref_clk, // system clock
  input wire logic i_rst, // power-on reset, sync active high
  input wire logic i_link_clk, // sampling clock for the serial pins
  input wire logic i_core_supply_rail_good, // core rail ok (pin)
  input wire logic i_osc_ok, // oscillator nominal and stable (pin)
  input wire logic i_reset_request_pin, // reset request pin
  input wire logic i_sleep_select_pin, // sleep select pin
  input wire logic i_fault, // any boost/amplifier/peak fault (pin)
  input wire logic i_boost_power_good, // boost power good (pin)
  input wire pwrseq_ctrl_type i_ctrl, // host-written controls
  input wire logic i_address_msb_select_wr, // write strobe for address msb
  input wire logic i_address_msb_select_val, // value written
  input wire logic [1:0] i_addr_option, // factory address option
  input wire logic [7:0] i_rd_data, // register data at pointer
  input wire logic i_scl, // serial clock pin
  input wire logic i_sda, // serial data pin
  output pwrseq_enables_type o_en, // block enables
  output logic [7:0] o_boost_level, // boost output setting
  output logic o_reset_done_event, // one-pulse reset-done event
  output logic o_clear_config, // pulse: clear configuration
  output logic o_address_msb_select, // current address msb select
  output logic o_sda_oe, // drive SDA low
  output logic o_sda_out, // SDA output value
  output logic [7:0] o_reg_ptr, // register pointer
  output logic o_wr_stb, // write strobe in system clock
  output logic [7:0] o_wr_data // write data
);
  // ---- system-domain input sync
  logic [1:0] s_core, s_osc, s_rst, s_slp, s_flt, s_pg;
  always_ff @(posedge i_ref_clk) begin
    s_core <= {s_core[0], i_core_supply_rail_good};
    s_osc <= {s_osc[0], i_osc_ok};
    s_rst <= {s_rst[0], i_reset_request_pin};
    s_slp <= {s_slp[0], i_sleep_select_pin};
    s_flt <= {s_flt[0], i_fault};
    s_pg <= {s_pg[0], i_boost_power_good};
  end

  logic slp_req;
  logic [15:0] slp_cnt;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      slp_req <= 1'b0;
      slp_cnt <= '0;
    end else if ((s_slp[1] ^ i_ctrl.sleep_pol) == slp_req) begin
      slp_cnt <= '0;
    end else if (slp_cnt == 16'(SLEEP_DEBOUNCE_CYC - 1)) begin
      slp_req <= ~slp_req;
      slp_cnt <= '0;
    end else begin
      slp_cnt <= slp_cnt + 16'h0001;
    end
  end

  logic rst_req;
  logic [7:0] rst_cnt;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rst_req <= 1'b0;
      rst_cnt <= '0;
    end else if (s_rst[1] == rst_req) begin
      rst_cnt <= '0;
    end else if (rst_cnt == 8'(RST_DEBOUNCE_CYC - 1)) begin
      rst_req <= ~rst_req;
      rst_cnt <= '0;
    end else begin
      rst_cnt <= rst_cnt + 8'h01;
    end
  end

  // ---- ramp tick
  logic [11:0] tick_cnt;
  logic tick;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || tick_cnt == 12'(RAMP_STEP_CYC - 1)) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 12'h001;
    end
  end
  assign tick = (tick_cnt == 12'(RAMP_STEP_CYC - 1));

  // ---- main sequencer
  pwrseq_state_type state;
  logic [4:0] gap;
  logic ramp_up_done;
  logic sleep_pending;
  logic fault_hold;
  logic gap_done;
  assign gap_done = (gap == 5'(SEQ_GAP_CYC - 1));
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      gap <= '0;
    end else if (gap_done || state == PS_RUN || state == PS_SLEEP) begin
      gap <= '0;
    end else begin
      gap <= gap + 5'h01;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state <= PS_OFF;
      o_en <= '0;
      o_boost_level <= '0;
      o_reset_done_event <= 1'b0;
      o_clear_config <= 1'b0;
      ramp_up_done <= 1'b0;
      sleep_pending <= 1'b0;
      fault_hold <= 1'b0;
    end else begin
      o_reset_done_event <= 1'b0;
      o_clear_config <= 1'b0;
      // re-enable seen as enable bits dropping and returning
      if (!(i_ctrl.amp_en && i_ctrl.boost_en)) fault_hold <= 1'b0;
      unique case (state)
        PS_OFF: if (s_core[1] && gap_done) begin
          o_en.clk_en <= 1'b1;
          state <= PS_CLK;
        end
        PS_CLK: if (gap_done) begin
          o_en.buck_en <= 1'b1;
          state <= PS_BUCK;
        end
        PS_BUCK: if (gap_done) begin
          o_en.ldo_en <= 1'b1;
          state <= PS_LDO;
        end
        PS_LDO: if (gap_done) state <= PS_RUN;
        PS_RUN: begin
          if (rst_req) begin
            state <= PS_RSTDN;
          end else if (s_flt[1] || slp_req || !i_ctrl.boost_en) begin
            sleep_pending <= slp_req;
            if (s_flt[1]) fault_hold <= 1'b1;
            state <= PS_RAMPDN;
          end else if (s_osc[1] && !fault_hold) begin
            o_en.boost_en <= 1'b1;
            if (tick && o_boost_level < i_ctrl.boost_target) begin
              o_boost_level <= o_boost_level + 8'({5'h00, i_ctrl.ramp_speed}) + BOOST_STEP;
            end
            ramp_up_done <= (o_boost_level >= i_ctrl.boost_target) && s_pg[1];
            o_en.amp_en <= i_ctrl.amp_en && (!i_ctrl.amp_gated || s_pg[1] || ramp_up_done);
          end
          if (!i_ctrl.amp_en) o_en.amp_en <= 1'b0;
        end
        PS_RAMPDN: begin
          // gated disable waits for ramp end
          if (!i_ctrl.amp_en && !i_ctrl.amp_gated) o_en.amp_en <= 1'b0;
          if (rst_req) begin
            state <= PS_RSTDN;
          end else if (tick && o_boost_level != 8'h00) begin
            o_boost_level <= o_boost_level - BOOST_STEP;
          end else if (o_boost_level == 8'h00) begin
            ramp_up_done <= 1'b0;
            if (slp_req) begin
              o_en.amp_en <= 1'b0;
              o_en.boost_en <= 1'b0;
              o_en.sleep_blocks_off <= 1'b1;
              o_en.ldo_sleep_level <= 1'b1;
              state <= PS_SLEEP;
            end else begin
              if (fault_hold) begin
                o_en.amp_en <= 1'b0;
                o_en.boost_en <= 1'b0;
              end else if (!i_ctrl.amp_en || (i_ctrl.amp_gated && !i_ctrl.boost_en && !sleep_pending)) begin
                o_en.amp_en <= 1'b0;
              end
              sleep_pending <= 1'b0;
              state <= PS_RUN;
            end
          end
        end
        PS_SLEEP: begin
          if (rst_req) begin
            state <= PS_RSTDN;
          end else if (!slp_req) begin
            o_en.ldo_sleep_level <= 1'b0;
            state <= PS_WAKE;
          end
        end
        PS_WAKE: if (gap_done) begin
          o_en.sleep_blocks_off <= 1'b0;
          o_en.amp_en <= i_ctrl.amp_en && !i_ctrl.amp_gated;
          state <= PS_RUN;
        end
        PS_RSTDN: begin
          o_en.amp_en <= 1'b0;
          o_en.boost_en <= 1'b0;
          o_boost_level <= '0;
          ramp_up_done <= 1'b0;
          fault_hold <= 1'b0;
          if (gap_done) state <= PS_RSTOFF;
        end
        PS_RSTOFF: begin
          o_en.sleep_blocks_off <= 1'b1;
          o_en.ldo_sleep_level <= 1'b0;
          // hard reset drops regulator and buck
          if (!i_ctrl.soft_reset_mode) begin
            o_en.ldo_en <= 1'b0;
            o_en.buck_en <= 1'b0;
          end
          if (gap_done && !rst_req) begin
            o_clear_config <= !i_ctrl.soft_reset_mode;
            o_reset_done_event <= 1'b1;
            o_en.sleep_blocks_off <= 1'b0;
            state <= i_ctrl.soft_reset_mode ? PS_RUN : PS_CLK;
          end
        end
        default: state <= PS_OFF;
      endcase
    end
  end

  // msb select kept by soft reset
  logic msb_sel;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || o_clear_config) begin
      msb_sel <= 1'b0;
    end else if (i_address_msb_select_wr) begin
      msb_sel <= i_address_msb_select_val;
    end
  end
  always_ff @(posedge i_ref_clk) o_address_msb_select <= msb_sel;

  // ---- link domain
  logic [2:0] l_scl, l_sda;
  logic [1:0] l_rst, l_msb;
  always_ff @(posedge i_link_clk) begin
    l_scl <= {l_scl[1:0], i_scl};
    l_sda <= {l_sda[1:0], i_sda};
    l_rst <= {l_rst[0], i_rst};
    l_msb <= {l_msb[0], msb_sel};
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = l_scl[1] && !l_scl[2];
  assign scl_fall = !l_scl[1] && l_scl[2];
  assign start_c = l_scl[1] && l_scl[2] && !l_sda[1] && l_sda[2];
  assign stop_c = l_scl[1] && l_scl[2] && l_sda[1] && !l_sda[2];

  pwrseq_i2c_state_type ist;
  logic [7:0] sh, ptr, rbuf;
  logic [3:0] bitn;
  logic rd, got_ptr, addr_msb_live, wr_tgl, data_ack;
  logic [7:0] wr_byte;
  always_ff @(posedge i_link_clk) begin
    if (l_rst[1]) begin
      ist <= IS_IDLE;
      sh <= '0;
      ptr <= REG_PTR_RST;
      bitn <= '0;
      rd <= 1'b0;
      got_ptr <= 1'b0;
      addr_msb_live <= 1'b0;
      wr_tgl <= 1'b0;
      data_ack <= 1'b0;
      wr_byte <= '0;
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
      rbuf <= '0;
    end else if (stop_c) begin
      ist <= IS_IDLE;
      o_sda_oe <= 1'b0;
      addr_msb_live <= l_msb[1];
    end else if (start_c) begin
      ist <= IS_ADDR;
      bitn <= '0;
      o_sda_oe <= 1'b0;
    end else begin
      unique case (ist)
        IS_IDLE: o_sda_oe <= 1'b0;
        IS_ADDR, IS_WBYTE: if (scl_rise) begin
          sh <= {sh[6:0], l_sda[1]};
          bitn <= bitn + 4'h1;
        end else if (scl_fall && bitn == 4'h8) begin
          bitn <= '0;
          if (ist == IS_ADDR) begin
            if (sh[7:1] == {addr_msb_live, 1'b0, addr_opt(i_addr_option)}) begin
              rd <= sh[0];
              got_ptr <= 1'b0;
              o_sda_oe <= 1'b1;
              ist <= IS_AACK;
            end else begin
              ist <= IS_IDLE;
            end
          end else begin
            if (!got_ptr) begin
              ptr <= sh;
              got_ptr <= 1'b1;
              data_ack <= 1'b0;
            end else begin
              wr_byte <= sh;
              wr_tgl <= ~wr_tgl;
              data_ack <= 1'b1;
            end
            o_sda_oe <= 1'b1;
            ist <= IS_WACK;
          end
        end
        IS_AACK, IS_WACK: if (scl_fall) begin
          o_sda_oe <= 1'b0;
          // step pointer once the data byte is acknowledged
          if (ist == IS_WACK && data_ack) ptr <= ptr + 8'h01;
          if (rd) begin
            rbuf <= i_rd_data;
            o_sda_oe <= !i_rd_data[7];
            bitn <= 4'h1;
            ist <= IS_RBYTE;
          end else begin
            ist <= IS_WBYTE;
          end
        end
        IS_RBYTE: if (scl_fall) begin
          if (bitn == 4'h8) begin
            o_sda_oe <= 1'b0;
            ptr <= ptr + 8'h01;
            ist <= IS_RACK;
          end else begin
            o_sda_oe <= !rbuf[3'(7 - bitn)];
            bitn <= bitn + 4'h1;
          end
        end
        IS_RACK: if (scl_rise) begin
          ist <= l_sda[1] ? IS_IDLE : IS_AACK;
        end
        default: ist <= IS_IDLE;
      endcase
    end
  end

  // toggle delayed one link cycle so the byte is settled first
  logic wr_tgl_d;
  always_ff @(posedge i_link_clk) begin
    wr_tgl_d <= wr_tgl;
  end

  function automatic logic [4:0] addr_opt(input logic [1:0] sel);
    unique case (sel)
      2'h0: addr_opt = ADDR_OPT0;
      2'h1: addr_opt = ADDR_OPT1;
      2'h2: addr_opt = ADDR_OPT2;
      default: addr_opt = ADDR_OPT3;
    endcase
  endfunction : addr_opt

  // write event crossing by toggle; data stable until next byte
  logic [2:0] s_tgl;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_tgl <= '0;
      o_wr_stb <= 1'b0;
      o_wr_data <= '0;
    end else begin
      s_tgl <= {s_tgl[1:0], wr_tgl_d};
      o_wr_stb <= s_tgl[1] ^ s_tgl[2];
      if (s_tgl[1] ^ s_tgl[2]) begin
        o_wr_data <= wr_byte;
      end
    end
  end
  // pointer shown to the register file is sampled in system domain
  logic [7:0] ptr_s1, ptr_s2;
  always_ff @(posedge i_ref_clk) begin
    ptr_s1 <= ptr;
    ptr_s2 <= ptr_s1;
    o_reg_ptr <= ptr_s2;
  end
endmodule : pwrseq_top

// ### src/pwrseq_pkg.sv
// Purpose: shared constants and types for the power sequencer with serial control
// Assumes: 125 MHz system clock
// Notes: timing constants derived from printed figures
package pwrseq_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned SLEEP_DEBOUNCE_US = 20;
  localparam int unsigned SLEEP_DEBOUNCE_CYC = SLEEP_DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned RST_DEBOUNCE_CYC = 64;
  localparam int unsigned RAMP_STEP_US = 20;
  localparam int unsigned RAMP_STEP_CYC = RAMP_STEP_US * CLK_MHZ;
  localparam int unsigned SEQ_GAP_CYC = 16;
  localparam logic [7:0] BOOST_STEP = 8'h01;
  localparam logic [4:0] ADDR_OPT0 = 5'h10;
  localparam logic [4:0] ADDR_OPT1 = 5'h14;
  localparam logic [4:0] ADDR_OPT2 = 5'h18;
  localparam logic [4:0] ADDR_OPT3 = 5'h1C;
  localparam logic [1:0] ADDR_OPT_RST = 2'h1;
  localparam logic [7:0] REG_PTR_RST = 8'h00;

  typedef enum logic [3:0] {
    PS_OFF = 4'h0,
    PS_CLK = 4'h1,
    PS_BUCK = 4'h2,
    PS_LDO = 4'h3,
    PS_RUN = 4'h4,
    PS_RAMPDN = 4'h5,
    PS_SLEEP = 4'h6,
    PS_WAKE = 4'h7,
    PS_RSTDN = 4'h8,
    PS_RSTOFF = 4'h9
  } pwrseq_state_type;

  typedef enum logic [2:0] {
    IS_IDLE = 3'h0,
    IS_ADDR = 3'h1,
    IS_AACK = 3'h2,
    IS_WBYTE = 3'h3,
    IS_WACK = 3'h4,
    IS_RBYTE = 3'h5,
    IS_RACK = 3'h6
  } pwrseq_i2c_state_type;

  typedef struct packed {
    logic clk_en;
    logic buck_en;
    logic ldo_en;
    logic ldo_sleep_level;
    logic boost_en;
    logic amp_en;
    logic sleep_blocks_off;
  } pwrseq_enables_type;

  typedef struct packed {
    logic boost_en;
    logic amp_en;
    logic amp_gated;
    logic sleep_pol;
    logic soft_reset_mode;
    logic [7:0] boost_target;
    logic [2:0] ramp_speed;
  } pwrseq_ctrl_type;
endpackage : pwrseq_pkg

// ### verification/pwrseq_assertions.sv
// Purpose: port-level sequencing checks for pwrseq_top
// Assumes: one ref clock domain, sync active-high reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
module pwrseq_assertions
  import pwrseq_pkg::*;
(
  input wire logic i_ref_clk, // system clock
  input wire logic i_rst, // sync reset
  input wire pwrseq_ctrl_type i_ctrl, // host controls
  input wire logic i_boost_power_good, // boost power good pin
  input wire pwrseq_enables_type o_en, // block enables
  input wire logic [7:0] o_boost_level, // boost setting
  input wire logic o_reset_done_event, // reset done pulse
  input wire logic o_sda_oe, // sda pulled low
  input wire logic o_sda_out // sda value
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_buck_after_clk: assert property ($rose(o_en.buck_en) |-> o_en.clk_en && $past(o_en.clk_en, 8))
    else $error("buck enabled too soon after clock");
  a_ldo_after_buck: assert property ($rose(o_en.ldo_en) |-> $past(o_en.buck_en, 8))
    else $error("regulator enabled too soon after buck");
  a_boost_needs_power: assert property (o_en.boost_en |-> o_en.ldo_en && o_en.clk_en)
    else $error("boost enabled before power-up done");
  a_amp_by_host: assert property ($rose(o_en.amp_en) |-> i_ctrl.amp_en)
    else $error("amplifier enabled without host bit");
  a_drivers_first: assert property ($fell(o_en.buck_en) || $fell(o_en.ldo_en) |-> !o_en.boost_en && !o_en.amp_en)
    else $error("supply dropped while drivers on");
  a_done_after_off: assert property (o_reset_done_event |-> (!o_en.boost_en && !o_en.amp_en) ##1 !o_reset_done_event)
    else $error("reset done event early or too long");
  a_ramp_slope: assert property ((o_boost_level < $past(o_boost_level))
    |-> ($past(o_boost_level) - o_boost_level == 8'h01) ##1 $stable(o_boost_level)[*8])
    else $error("boost ramp-down step wrong");
  a_amp_off_late: assert property ($fell(o_en.amp_en) && i_ctrl.amp_en |-> o_boost_level == 8'h00)
    else $error("amplifier off before ramp-down end");
  a_sleep_keeps_buck: assert property (o_en.ldo_sleep_level |-> o_en.buck_en && o_en.clk_en && !o_en.amp_en)
    else $error("wrong enables in sleep");
  a_wake_ldo_first: assert property ($fell(o_en.ldo_sleep_level) |-> !o_en.amp_en)
    else $error("amplifier on before regulator restored");
  a_amp_waits_good: assert property ($rose(o_en.amp_en) && i_ctrl.amp_gated |-> $past(i_boost_power_good, 2))
    else $error("gated amplifier on before power good");
  a_sda_low_only: assert property (o_sda_oe |-> !o_sda_out)
    else $error("sda driven high");
endmodule : pwrseq_assertions

bind pwrseq_top pwrseq_assertions u_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ctrl(i_ctrl), .i_boost_power_good(i_boost_power_good),
  .o_en(o_en), .o_boost_level(o_boost_level), .o_reset_done_event(o_reset_done_event),
  .o_sda_oe(o_sda_oe), .o_sda_out(o_sda_out));

// ### verification/pwrseq_i2c_host.sv
// Purpose: host-side serial bus master model
// Assumes: SDA resolved with a pull-up in the bench
// Notes: 1 MHz bus, SCL stands high between frames
`timescale 1ns/1ps
module pwrseq_i2c_host (
  input wire logic i_sda, // resolved data line
  output logic o_scl, // bus clock
  output logic o_sda_low, // pull data low
  output logic [7:0] o_rd_byte, // last byte read
  output logic o_rd_done // pulse per byte read
);
  localparam time QTR = 250;
  initial begin
    o_scl = 1'h1;
    o_sda_low = 1'h0;
    o_rd_byte = 8'h00;
    o_rd_done = 1'h0;
  end
  // data moves only while clock is low
  task automatic clk_bit(input logic b, output logic s);
    o_sda_low = !b;
    #QTR;
    o_scl = 1'h1;
    #QTR;
    s = i_sda;
    #QTR;
    o_scl = 1'h0;
    #QTR;
  endtask : clk_bit
  task automatic start_cond;
    o_sda_low = 1'h0;
    #QTR;
    o_scl = 1'h1;
    #QTR;
    o_sda_low = 1'h1;
    #QTR;
    o_scl = 1'h0;
    #QTR;
  endtask : start_cond
  task automatic stop_cond;
    o_sda_low = 1'h1;
    #QTR;
    o_scl = 1'h1;
    #QTR;
    o_sda_low = 1'h0;
    #QTR;
  endtask : stop_cond
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'h1, s);
    ack = !s;
  endtask : wr_byte
  // ack every byte but the last
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 0; i < 8; i++) begin
      clk_bit(1'h1, s);
      d = {d[6:0], s};
    end
    clk_bit(last, s);
    o_rd_byte = d;
    o_rd_done = 1'h1;
    #1;
    o_rd_done = 1'h0;
  endtask : rd_byte
endmodule : pwrseq_i2c_host

// ### verification/pwrseq_top_tb_top.sv
// Purpose: self-checking bench for pwrseq_top
// Assumes: host model on the bus, SDA pulled up
// Notes: bus results checked against a queue of expected bytes
`timescale 1ns/1ps
module pwrseq_top_tb_top
  import pwrseq_pkg::*;
;
  logic clk = 1'h0;
  logic link = 1'h0;
  logic rst = 1'h1;
  logic core_ok, osc_ok, rst_pin, sleep_select_pin, fault, msb_wr, msb_val;
  logic pg = 1'h0;
  logic [1:0] opt;
  logic [7:0] rd_data = 8'h00;
  pwrseq_ctrl_type ctrl;
  pwrseq_enables_type en;
  logic [7:0] lvl, ptr, wr_data, rd_byte;
  logic done_ev, clr_cfg, msb, sda_oe, sda_out, wr_stb, scl, host_low, rd_done;
  wire sda = !(host_low || sda_oe);
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int clr_seen = 0;
  logic [7:0] exp_q[$];
  logic [4:0] opts[4] = '{ADDR_OPT0, ADDR_OPT1, ADDR_OPT2, ADDR_OPT3};

  initial forever #4 clk = ~clk;
  initial begin
    #7;
    forever #24 link = ~link;
  end

  pwrseq_top u_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_link_clk(link), .i_core_supply_rail_good(core_ok),
    .i_osc_ok(osc_ok), .i_reset_request_pin(rst_pin), .i_sleep_select_pin(sleep_select_pin), .i_fault(fault),
    .i_boost_power_good(pg), .i_ctrl(ctrl), .i_address_msb_select_wr(msb_wr),
    .i_address_msb_select_val(msb_val), .i_addr_option(opt), .i_rd_data(rd_data), .i_scl(scl),
    .i_sda(sda), .o_en(en), .o_boost_level(lvl), .o_reset_done_event(done_ev),
    .o_clear_config(clr_cfg), .o_address_msb_select(msb), .o_sda_oe(sda_oe), .o_sda_out(sda_out),
    .o_reg_ptr(ptr), .o_wr_stb(wr_stb), .o_wr_data(wr_data));
  pwrseq_i2c_host u_host (.i_sda(sda), .o_scl(scl), .o_sda_low(host_low), .o_rd_byte(rd_byte),
    .o_rd_done(rd_done));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic take(input logic [7:0] got);
    logic [7:0] exp;
    exp = exp_q.size() > 0 ? exp_q.pop_front() : ~got;
    check(got, exp);
  endtask : take
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  function automatic logic [6:0] dev_addr(input logic m);
    dev_addr = {m, 1'h0, opts[opt]};
  endfunction : dev_addr
  task automatic i2c_write(input logic [6:0] a, input logic [7:0] p, input int n, input logic ack_exp);
    logic ack;
    logic [7:0] d;
    u_host.start_cond();
    u_host.wr_byte({a, 1'h0}, ack);
    check({7'h00, ack}, {7'h00, ack_exp});
    if (ack) begin
      u_host.wr_byte(p, ack);
      repeat (n) begin
        d = 8'($urandom);
        exp_q.push_back(d);
        u_host.wr_byte(d, ack);
      end
    end
    u_host.stop_cond();
    tick(8);
    if (ack_exp) check(ptr, 8'(p + n));
  endtask : i2c_write
  task automatic i2c_read(input logic [6:0] a, input logic [7:0] p);
    logic ack;
    logic [7:0] d;
    u_host.start_cond();
    u_host.wr_byte({a, 1'h0}, ack);
    u_host.wr_byte(p, ack);
    u_host.start_cond();
    u_host.wr_byte({a, 1'h1}, ack);
    check({7'h00, ack}, 8'h01);
    exp_q.push_back(p ^ 8'hA5);
    exp_q.push_back(8'(p + 8'h01) ^ 8'hA5);
    u_host.rd_byte(1'h0, d);
    u_host.rd_byte(1'h1, d);
    u_host.stop_cond();
  endtask : i2c_read

  always @(posedge clk) begin
    rd_data <= #1 ptr ^ 8'hA5;
    pg <= #1 en.boost_en && lvl == ctrl.boost_target;
    if (clr_cfg) clr_seen++;
    if (wr_stb) take(wr_data);
    cycles++;
    if (cycles == 99000) begin
      err_count++;
      report_and_stop();
    end
  end
  always @(posedge rd_done) take(rd_byte);

  initial begin
    void'($urandom(32'h3C62C61F));
    {core_ok, osc_ok, rst_pin, sleep_select_pin, fault, msb_wr, msb_val} = 7'h00;
    opt = 2'h1;
    ctrl = '{boost_en: 1'h1, amp_en: 1'h1, amp_gated: 1'h1, sleep_pol: 1'h0, soft_reset_mode: 1'h1,
      boost_target: 8'h04, ramp_speed: 3'h3};
    tick(20);
    rst = 1'h0;
    tick(40);
    check({1'h0, en}, 8'h00);
    core_ok = 1'h1;
    repeat (300) if (!en.ldo_en) tick(1);
    tick(100);
    check({1'h0, en}, 8'h70);
    for (int o = 0; o < 4; o++) begin
      opt = 2'(o);
      i2c_write(dev_addr(1'h0), 8'($urandom), 1, 1'h1);
    end
    i2c_write(dev_addr(1'h1), 8'h10, 0, 1'h0);
    i2c_read(dev_addr(1'h0), 8'($urandom));
    msb_wr = 1'h1;
    msb_val = 1'h1;
    tick(1);
    msb_wr = 1'h0;
    tick(10);
    check({7'h00, msb}, 8'h01);
    i2c_write(dev_addr(1'h0), 8'h20, 0, 1'h1);
    i2c_write(dev_addr(1'h1), 8'h21, 0, 1'h1);
    i2c_write(dev_addr(1'h0), 8'h22, 0, 1'h0);
    rst_pin = 1'h1;
    tick(200);
    rst_pin = 1'h0;
    repeat (400) if (!done_ev) tick(1);
    check({7'h00, done_ev}, 8'h01);
    check({1'h0, en}, 8'h70);
    check({7'h00, msb}, 8'h01);
    check(8'(clr_seen), 8'h00);
    ctrl.soft_reset_mode = 1'h0;
    rst_pin = 1'h1;
    repeat (400) if (en.buck_en) tick(1);
    check({1'h0, en}, 8'h41);
    rst_pin = 1'h0;
    repeat (400) if (!done_ev) tick(1);
    check({7'h00, done_ev}, 8'h01);
    tick(2);
    check(8'(clr_seen), 8'h01);
    check({7'h00, msb}, 8'h00);
    repeat (300) if (!en.ldo_en) tick(1);
    osc_ok = 1'h1;
    repeat (20000) if (lvl !== 8'h04) tick(1);
    tick(20);
    check({1'h0, en}, 8'h76);
    ctrl.amp_gated = 1'h0;
    fault = 1'h1;
    tick(10);
    fault = 1'h0;
    repeat (20000) if (lvl !== 8'h01) tick(1);
    check({7'h00, en.amp_en}, 8'h01);
    repeat (5000) if (lvl !== 8'h00) tick(1);
    tick(20);
    check({7'h00, en.amp_en}, 8'h00);
    ctrl.boost_en = 1'h0;
    ctrl.amp_en = 1'h0;
    tick(10);
    ctrl.boost_en = 1'h1;
    ctrl.amp_en = 1'h1;
    repeat (20000) if (lvl !== 8'h04) tick(1);
    tick(20);
    check({1'h0, en}, 8'h76);
    sleep_select_pin = 1'h1;
    repeat (20000) if (lvl !== 8'h03) tick(1);
    sleep_select_pin = 1'h0;
    repeat (20000) if (lvl !== 8'h00) tick(1);
    tick(20);
    check({1'h0, en}, 8'h76);
    repeat (20000) if (lvl !== 8'h04) tick(1);
    tick(20);
    sleep_select_pin = 1'h1;
    tick(1000);
    check({7'h00, en.ldo_sleep_level}, 8'h00);
    repeat (20000) if (!en.ldo_sleep_level) tick(1);
    tick(5);
    check({1'h0, en} & 8'h7B, 8'h79);
    sleep_select_pin = 1'h0;
    tick(1000);
    check({7'h00, en.ldo_sleep_level}, 8'h01);
    repeat (20000) if (lvl !== 8'h04) tick(1);
    tick(20);
    check({1'h0, en}, 8'h76);
    check(8'(exp_q.size()), 8'h00);
    report_and_stop();
  end
endmodule : pwrseq_top_tb_top
